// ---- watchdog_timer.sv ----
// Watchdog timer with timed unlock, APB slave, reset cause flag and interrupt
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module watchdog_timer
  import wdt_pkg::*;
#(
  parameter int OSC_DIV   = osc_div,
  parameter int BASE_CNT  = base_cycles
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        always_on_fuse,
  input  wire logic        restart_instruction,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             chip_reset,
  output logic             irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic        wr_en;
  logic        rd_en;
  logic        wr_ctrl;
  logic        wr_cause;
  logic        wr_mask;
  logic        wr_restart;
  logic        rd_stat;
  logic        mapped;
  logic        fuse_q;
  logic        fuse_s1_q;
  logic        fuse_s2_q;
  logic        fuse_s3_q;
  logic        enable_q;
  logic        change_en_q;
  logic [2:0]  window_q;
  logic [2:0]  sel_q;
  logic        dog_flag_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [21:0] count_q;
  logic [21:0] limit;
  logic        osc_tick;
  logic        timeout;
  logic        enable_eff;
  logic        wr_change;
  logic        wr_enable;
  logic [2:0]  wr_sel;
  logic        window_open;
  logic        unlock_write;

  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && penable && !pwrite;
  assign mapped     = (paddr == ctrl_offset) || (paddr == cause_offset) || (paddr == irq_stat_offset)
                      || (paddr == irq_mask_offset) || (paddr == restart_offset);
  assign wr_ctrl    = wr_en && (paddr == ctrl_offset);
  assign wr_cause   = wr_en && (paddr == cause_offset);
  assign wr_mask    = wr_en && (paddr == irq_mask_offset);
  assign wr_restart = wr_en && (paddr == restart_offset);
  // Clear on the setup edge, where the read image is latched, so no event is lost
  assign rd_stat    = psel && !penable && !pwrite && (paddr == irq_stat_offset);

  assign wr_change    = pwdata[change_en_bit];
  assign wr_enable    = pwdata[enable_bit];
  assign wr_sel       = pwdata[2:0];
  assign window_open  = change_en_q;
  assign unlock_write = wr_ctrl && wr_change && wr_enable;
  assign enable_eff   = fuse_q || enable_q;

  // ****************************************
  // Fuse capture after reset release
  // ****************************************
  // Pin is asynchronous: three stages, accepted once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      fuse_s3_q <= 1'b0;
      fuse_q    <= 1'b0;
    end else begin
      fuse_s1_q <= always_on_fuse;
      fuse_s2_q <= fuse_s1_q;
      fuse_s3_q <= fuse_s2_q;
      if (fuse_s2_q == fuse_s3_q) begin
        fuse_q <= fuse_s3_q;
      end
    end
  end

  // ****************************************
  // Change-enable window
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      change_en_q <= 1'b0;
      window_q    <= 3'h0;
    end else if (unlock_write) begin
      change_en_q <= 1'b1;
      window_q    <= window_cycles;
    end else if (window_q == 3'h1) begin
      change_en_q <= 1'b0;
      window_q    <= 3'h0;
    end else if (window_q != 3'h0) begin
      window_q    <= window_q - 3'h1;
    end
  end

  // ****************************************
  // Enable and timeout select
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      if (wr_enable) begin
        enable_q <= 1'b1;
      end else if (window_open && !wr_change) begin
        enable_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= sel_reset;
    end else if (wr_ctrl && window_open && !wr_change) begin
      sel_q <= wr_sel;
    end
  end

  // ****************************************
  // Watchdog counter
  // ****************************************
  wdt_osc_tick #(
    .DIV (OSC_DIV)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (osc_tick)
  );

  assign limit   = 22'(BASE_CNT) << sel_q;
  assign timeout = enable_eff && osc_tick && (count_q == limit - 22'h1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 22'h0;
    end else if (!enable_eff || restart_instruction || wr_restart || timeout) begin
      count_q <= 22'h0;
    end else if (osc_tick) begin
      count_q <= count_q + 22'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= timeout;
    end
  end

  // ****************************************
  // Reset cause flag (kept through chip reset)
  // ****************************************
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      dog_flag_q <= 1'b0;
    end else if (timeout) begin
      dog_flag_q <= 1'b1;
    end else if (wr_cause && !pwdata[dog_flag_bit]) begin
      dog_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= irq_reset;
    end else begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | {timeout, unlock_write};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= irq_reset;
    end else if (wr_mask) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // APB read data and response
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        if (paddr == ctrl_offset) begin
          prdata <= {27'h0, change_en_q, enable_eff, sel_q};
        end else if (paddr == cause_offset) begin
          prdata <= {28'h0, dog_flag_q, 3'h0};
        end else if (paddr == irq_stat_offset) begin
          prdata <= {30'h0, irq_stat_q};
        end else if (paddr == irq_mask_offset) begin
          prdata <= {30'h0, irq_mask_q};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

endmodule : watchdog_timer

// ---- wdt_pkg.sv ----
// Package with register map, field layout and timing constants for the watchdog block
package wdt_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ctrl_offset     = 8'h00;
  localparam logic [7:0] cause_offset    = 8'h04;
  localparam logic [7:0] irq_stat_offset = 8'h08;
  localparam logic [7:0] irq_mask_offset = 8'h0C;
  localparam logic [7:0] restart_offset  = 8'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int          change_en_bit   = 4;
  localparam int          enable_bit      = 3;
  localparam int          dog_flag_bit    = 3;
  localparam logic [2:0]  sel_reset       = 3'h0;
  localparam logic [1:0]  irq_reset       = 2'h0;
  localparam logic [2:0]  window_cycles   = 3'h4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          sys_clock_hz    = 40000000;
  localparam int          dog_osc_hz      = 1000000;
  localparam int          base_cycles     = 16384;
  localparam int          osc_div         = sys_clock_hz / dog_osc_hz;

  // Control register image
  typedef struct packed {
    logic [2:0] reserved;
    logic       change_en;
    logic       enable;
    logic [2:0] timeout_select;
  } watchdog_control_t;

endpackage : wdt_pkg

// ---- wdt_osc_tick.sv ----
// Divider producing the watchdog oscillator tick enable
`timescale 1ns/1ps
module wdt_osc_tick
  import wdt_pkg::*;
#(
  parameter int DIV = osc_div
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      tick
);

  logic [15:0] cnt_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule : wdt_osc_tick

// ---- wdt_chk_asserts.sv ----
// Port-level assertions for the watchdog block
`timescale 1ns/1ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        always_on_fuse,
  input wire logic        restart_instruction,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chip_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd_ctrl = pready && !pwrite && paddr == ctrl_offset;
  // ****************************************
  // Properties
  // ****************************************
  sequence s_setup; psel && !penable; endsequence
  sequence s_quiet; !chip_reset [*8]; endsequence
  property p_answer; s_setup |=> pready && penable; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready too long");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_unmapped; pready && paddr > restart_offset |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_reserved; rd_ctrl |-> prdata[7:5] == 3'h0; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_fuse_on; rd_ctrl && always_on_fuse |-> prdata[enable_bit]; endproperty
  a_fuse_on: assert property (p_fuse_on) else $error("enable low with fuse");
  property p_pulse; chip_reset |=> !chip_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_restart; restart_instruction |=> s_quiet; endproperty
  a_restart: assert property (p_restart) else $error("reset soon after restart");
endmodule : wdt_chk

bind watchdog_timer wdt_chk chk_u (.clock(clock), .rst_n(rst_n), .always_on_fuse(always_on_fuse),
  .restart_instruction(restart_instruction), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_reset(chip_reset));

// ---- tb_top.sv ----
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
module tb_top;
  import wdt_pkg::*;
  logic        clock, rst_n, por_n, fuse, rsi, psel, penable, pwrite, pready, pslverr, chip_reset, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, comparisons, cyc, hits, n0, n1;
  watchdog_timer #(.OSC_DIV(2), .BASE_CNT(8)) dut_u (.clock(clock), .rst_n(rst_n), .por_n(por_n),
    .always_on_fuse(fuse), .restart_instruction(rsi), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_reset(chip_reset), .irq(irq));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset
  task automatic measure(input logic [2:0] sel, output int n);
    do_reset();
    apb(1'b1, irq_mask_offset, 32'h2);
    apb(1'b1, ctrl_offset, 32'h18);
    apb(1'b1, ctrl_offset, {29'h1, sel});
    rsi <= 1'b1;
    @(posedge clock);
    rsi <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!chip_reset && n < 300);
  endtask : measure
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_window;
    do_reset();
    rdc(ctrl_offset, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ctrl_offset, 32'h08);
    apb(1'b1, ctrl_offset, 32'h1F);
    rdc(ctrl_offset, 32'h18);
    repeat (6) @(posedge clock);
    rdc(ctrl_offset, 32'h08);
    apb(1'b1, ctrl_offset, 32'h0B);
    rdc(ctrl_offset, 32'h08);
    apb(1'b1, ctrl_offset, 32'h00);
    rdc(ctrl_offset, 32'h08);
    apb(1'b1, ctrl_offset, 32'h18);
    apb(1'b1, ctrl_offset, 32'h02);
    rdc(ctrl_offset, 32'h02);
  endtask : t_window
  task automatic t_restart;
    do_reset();
    apb(1'b1, ctrl_offset, 32'h08);
    n0 = hits;
    for (int i = 0; i < 6; i++) begin
      repeat (6) @(posedge clock);
      rsi <= 1'b1;
      @(posedge clock);
      rsi <= 1'b0;
      apb(1'b1, restart_offset, 32'h0);
    end
    chk(hits - n0, 0);
  endtask : t_restart
  task automatic t_timeout;
    measure(3'h0, n0);
    chk(n0 >= 14 && n0 <= 20, 1);
    repeat (3) @(negedge clock);
    chk(irq, 1'b1);
    rdc(irq_stat_offset, 32'h3);
    rdc(cause_offset, 32'h8);
    @(negedge clock);
    chk(irq, 1'b0);
    measure(3'h1, n1);
    chk(n1 - n0 >= 15 && n1 - n0 <= 17, 1);
    do_reset();
    rdc(ctrl_offset, 32'h0);
    apb(1'b1, cause_offset, 32'h0);
    rdc(cause_offset, 32'h0);
  endtask : t_timeout
  task automatic t_fuse;
    fuse <= 1'b1;
    do_reset();
    apb(1'b1, ctrl_offset, 32'h00);
    rdc(ctrl_offset, 32'h08);
    apb(1'b1, ctrl_offset, 32'h18);
    apb(1'b1, ctrl_offset, 32'h03);
    rdc(ctrl_offset, 32'h0B);
  endtask : t_fuse
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (chip_reset === 1'b1) hits++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    {rst_n, por_n, fuse, rsi, psel, penable, pwrite, paddr, pwdata} = '0;
    t_window();
    t_restart();
    t_timeout();
    t_fuse();
    complete_run();
  end
endmodule : tb_top
